// file: verilog/pmc_pkg.sv
/*
 * constants for the global power-mode controller: mode codes, template widths,
 * wakeup source positions, resume timing.
 * assumes a single 10 MHz system clock.
 */
package pmc_pkg;
	// system clock rate
	localparam int unsigned CLK_HZ         = 10_000_000;
	// sleep resume time, microseconds
	localparam int unsigned SLEEP_RESUME_US = 15;
	// hibernate resume limit, microseconds (longest time)
	localparam int unsigned HIB_RESUME_US  = 100;
	// least wait for sleep exit, rounded up
	localparam int unsigned SLEEP_RESUME_CYC =
		(SLEEP_RESUME_US * (CLK_HZ / 1_000_000) + 0);
	// hibernate resume wait, less the two synchroniser flops, the detection edge
	// and one spare cycle, so pin event to active stays under the limit
	localparam int unsigned HIB_RESUME_CYC =
		(HIB_RESUME_US * (CLK_HZ / 1_000_000)) - 4;
	// counter width for resume waits
	localparam int unsigned CNT_W          = 10;
	// number of power-controllable subsystems
	localparam int unsigned NSUB           = 8;
	// template bit of the cpu and of flash
	localparam int unsigned SUB_CPU        = 0;
	localparam int unsigned SUB_FLASH      = 1;
	// subsystems kept alive in sleep (i2c address match, comparator)
	localparam logic [NSUB-1:0] SLEEP_KEEP = 8'h0C;
	// template reset values: everything on
	localparam logic [NSUB-1:0] TPL_RST    = 8'hFF;
	// sleep wakeup source positions
	localparam int unsigned NWAKE          = 6;
	localparam int unsigned WK_CMP         = 0;
	localparam int unsigned WK_PIN         = 1;
	localparam int unsigned WK_I2C         = 2;
	localparam int unsigned WK_RTC         = 3;
	localparam int unsigned WK_TWHEEL      = 4;
	localparam int unsigned WK_LVD         = 5;
	// regulator buzz period in sleep, cycles
	localparam int unsigned BUZZ_PERIOD    = 64;
	localparam int unsigned BUZZ_W         = 6;
	// requested-mode codes
	localparam logic [1:0] REQ_ALT         = 2'h1;
	localparam logic [1:0] REQ_SLEEP       = 2'h2;
	localparam logic [1:0] REQ_HIB         = 2'h3;
	// one-hot global modes
	typedef enum logic [5:0] {
		M_ACTIVE  = 6'h01,
		M_ALT     = 6'h02,
		M_SLEEP   = 6'h04,
		M_HIB     = 6'h08,
		M_RES_SLP = 6'h10,
		M_RES_HIB = 6'h20
	} mode_e;
endpackage

// file: verilog/power_mode_controller.sv
/*
 * global power-mode controller: four modes, subsystem templates, clock gating,
 * regulator drive, wakeup handling and resume waits.
 * assumes wakeup and reset-event inputs are asynchronous, other inputs are
 * on i_sys_clk; the cpu clock gate follows o_sub_en directly.
 */
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller (
	// clock and reset
	input  wire logic                      i_sys_clk,
	input  wire logic                      i_rst,
	// firmware controls
	input  wire logic [pmc_pkg::NSUB-1:0]  i_active_tpl,
	input  wire logic [pmc_pkg::NSUB-1:0]  i_alt_tpl,
	input  wire logic                      i_mode_req,
	input  wire logic [1:0]                i_mode_req_sel,
	input  wire logic                      i_dreg_en_clr,
	input  wire logic                      i_areg_en_clr,
	input  wire logic                      i_osc_sel_khz,
	// wakeup sources (asynchronous)
	input  wire logic [pmc_pkg::NWAKE-1:0] i_sleep_wake,
	input  wire logic                      i_any_irq,
	input  wire logic                      i_external_reset_pin,
	input  wire logic                      i_watchdog_reset,
	input  wire logic                      i_precision_reset,
	// subsystem enables and clock gates
	output logic [pmc_pkg::NSUB-1:0]       o_sub_en,
	output logic                           o_sys_clk_en,
	output logic                           o_internal_low_speed_osc_en,
	output logic                           o_khz_crystal_osc_en,
	// regulators
	output logic                           o_dreg_en,
	output logic                           o_areg_en,
	output logic                           o_hib_reg_en,
	// retention and status
	output logic                           o_io_hold,
	output logic                           o_retain,
	output logic [3:0]                     o_mode,
	output logic                           o_wake_pulse
);
	// synchronisers for asynchronous wake and reset events
	localparam int unsigned NSYNC = pmc_pkg::NWAKE + 4;
	logic [NSYNC-1:0] async_in;   // raw events
	logic [NSYNC-1:0] sync1_r;    // first stage, read only by second
	logic [NSYNC-1:0] sync2_r;    // usable levels
	assign async_in = {i_precision_reset, i_watchdog_reset, i_external_reset_pin,
		i_any_irq, i_sleep_wake};

	// two-flop synchroniser chain
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= async_in;
			sync2_r <= sync1_r;
		end
	end

	// decoded event levels
	wire [pmc_pkg::NWAKE-1:0] sleep_wk = sync2_r[pmc_pkg::NWAKE-1:0];
	wire irq_s       = sync2_r[pmc_pkg::NWAKE];
	wire rst_evt     = |sync2_r[NSYNC-1:pmc_pkg::NWAKE+1];
	wire pin_wake    = sleep_wk[pmc_pkg::WK_PIN];
	wire sleep_wake  = (|sleep_wk) | rst_evt;
	wire hib_wake    = pin_wake | rst_evt;
	wire any_wake    = irq_s | (|sleep_wk) | rst_evt;

	// state
	pmc_pkg::mode_e            mode_r, mode_nxt;  // global mode
	logic [pmc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;    // resume counter
	logic                      cpu_off_r, cpu_off_nxt; // cpu self-disabled
	logic                      cpu_tpl_r;         // cpu template bit one cycle ago
	logic                      dreg_on_r, areg_on_r;   // regulator enable bits
	logic [pmc_pkg::BUZZ_W-1:0] buzz_r;           // buzz phase
	logic                      wake_r;            // wake pulse flop

	// mode request decode, only honoured in active
	wire req_ok  = i_mode_req && (mode_r == pmc_pkg::M_ACTIVE);
	wire req_alt = req_ok && (i_mode_req_sel == pmc_pkg::REQ_ALT);
	wire req_slp = req_ok && (i_mode_req_sel == pmc_pkg::REQ_SLEEP);
	wire req_hib = req_ok && (i_mode_req_sel == pmc_pkg::REQ_HIB);
	// cpu clears its own template bit while active: act on the falling edge only,
	// so a bit left low does not switch the cpu off again right after a wakeup
	wire cpu_self_off = (mode_r == pmc_pkg::M_ACTIVE) && cpu_tpl_r
		&& !i_active_tpl[pmc_pkg::SUB_CPU];

	// next-mode logic
	always_comb begin
		mode_nxt    = mode_r;
		cnt_nxt     = cnt_r;
		cpu_off_nxt = cpu_off_r;
		unique case (mode_r)
			pmc_pkg::M_ACTIVE: begin
				// cpu self-disable latched, cleared by wakeup
				if (any_wake)
					cpu_off_nxt = 1'b0;
				else if (cpu_self_off)
					cpu_off_nxt = 1'b1;
				if (req_alt) begin
					mode_nxt = pmc_pkg::M_ALT;
				end else if (req_slp) begin
					mode_nxt = pmc_pkg::M_SLEEP;
				end else if (req_hib) begin
					mode_nxt = pmc_pkg::M_HIB;
				end
			end
			pmc_pkg::M_ALT: begin
				// any interrupt returns to active
				if (any_wake) begin
					mode_nxt    = pmc_pkg::M_ACTIVE;
					cpu_off_nxt = 1'b0;
				end
			end
			pmc_pkg::M_SLEEP: begin
				if (sleep_wake) begin
					mode_nxt = pmc_pkg::M_RES_SLP;
					cnt_nxt  = pmc_pkg::CNT_W'(pmc_pkg::SLEEP_RESUME_CYC - 1);
				end
			end
			pmc_pkg::M_HIB: begin
				if (hib_wake) begin
					mode_nxt = pmc_pkg::M_RES_HIB;
					cnt_nxt  = pmc_pkg::CNT_W'(pmc_pkg::HIB_RESUME_CYC - 1);
				end
			end
			pmc_pkg::M_RES_SLP, pmc_pkg::M_RES_HIB: begin
				// resume wait with regulators still held off, then active
				if (cnt_r == '0) begin
					mode_nxt    = pmc_pkg::M_ACTIVE;
					cpu_off_nxt = 1'b0;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			default: begin
				mode_nxt = pmc_pkg::M_ACTIVE; // illegal code recovers
			end
		endcase
	end

	// mode register, reset to active
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			mode_r    <= pmc_pkg::M_ACTIVE;
			cnt_r     <= '0;
			cpu_off_r <= 1'b0;
		end else begin
			mode_r    <= mode_nxt;
			cnt_r     <= cnt_nxt;
			cpu_off_r <= cpu_off_nxt;
		end
	end

	// last cpu template bit, edge detector for the self-disable
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			cpu_tpl_r <= pmc_pkg::TPL_RST[pmc_pkg::SUB_CPU];
		else
			cpu_tpl_r <= i_active_tpl[pmc_pkg::SUB_CPU];
	end

	// regulator enable bits, on after power-up, firmware clears
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			dreg_on_r <= 1'b1;
			areg_on_r <= 1'b1;
		end else begin
			if (i_dreg_en_clr)
				dreg_on_r <= 1'b0;
			if (i_areg_en_clr)
				areg_on_r <= 1'b0;
		end
	end

	// buzz phase counter, runs only in sleep
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			buzz_r <= '0;
		else if (mode_r == pmc_pkg::M_SLEEP)
			buzz_r <= buzz_r + 1'b1;
		else
			buzz_r <= '0;
	end

	// output decode
	wire in_act  = (mode_nxt == pmc_pkg::M_ACTIVE);
	wire in_alt  = (mode_nxt == pmc_pkg::M_ALT);
	wire in_slp  = (mode_nxt == pmc_pkg::M_SLEEP) || (mode_nxt == pmc_pkg::M_RES_SLP);
	wire in_hib  = (mode_nxt == pmc_pkg::M_HIB) || (mode_nxt == pmc_pkg::M_RES_HIB);
	wire buzz_on = (mode_nxt == pmc_pkg::M_SLEEP) && (buzz_r == '0);
	logic [pmc_pkg::NSUB-1:0] sub_nxt; // per-subsystem enable
	wire wake_nxt = (mode_nxt == pmc_pkg::M_ACTIVE) && (mode_r != pmc_pkg::M_ACTIVE);

	// per-subsystem enable: template in active (cpu: self-disable latch instead), alternate template, sleep keep
	for (genvar g = 0; g < pmc_pkg::NSUB; g++) begin : g_sub
		if (g == pmc_pkg::SUB_CPU) begin : g_cpu
			assign sub_nxt[g] = (in_act && !cpu_off_nxt) || (in_alt && i_alt_tpl[g]);
		end else begin : g_oth
			assign sub_nxt[g] = (in_act && i_active_tpl[g])
				|| (in_alt && i_alt_tpl[g])
				|| (in_slp && pmc_pkg::SLEEP_KEEP[g]);
		end
	end

	// registered outputs
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_sub_en      <= pmc_pkg::TPL_RST;
			o_sys_clk_en  <= 1'b1;
			o_internal_low_speed_osc_en <= 1'b1;
			o_khz_crystal_osc_en        <= 1'b0;
			o_dreg_en     <= 1'b1;
			o_areg_en     <= 1'b1;
			o_hib_reg_en  <= 1'b1;
			o_io_hold     <= 1'b0;
			o_retain      <= 1'b0;
			o_mode        <= 4'h1;
			wake_r        <= 1'b0;
		end else begin
			o_sub_en      <= sub_nxt;
			o_sys_clk_en  <= in_act || in_alt;
			o_internal_low_speed_osc_en <= !in_hib && !(in_slp && i_osc_sel_khz);
			o_khz_crystal_osc_en        <= in_slp && i_osc_sel_khz;
			o_dreg_en     <= dreg_on_r && !in_hib && (!in_slp || buzz_on);
			o_areg_en     <= areg_on_r && !in_hib && (!in_slp || buzz_on);
			o_hib_reg_en  <= 1'b1;
			o_io_hold     <= in_hib;
			o_retain      <= in_hib;
			o_mode        <= {in_hib, in_slp, in_alt, in_act};
			wake_r        <= wake_nxt;
		end
	end
	assign o_wake_pulse = wake_r;

	// assertions
	a_reset_active: assert property (@(posedge i_sys_clk) $fell(i_rst) |-> mode_r == pmc_pkg::M_ACTIVE)
		else $error("mode not active after reset");
	a_req_only_active: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(mode_r == pmc_pkg::M_ALT && !any_wake) |=> mode_r == pmc_pkg::M_ALT)
		else $error("alternate mode left without wakeup");
	a_hib_pin_only: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(mode_r == pmc_pkg::M_HIB && !hib_wake) |=> mode_r == pmc_pkg::M_HIB)
		else $error("hibernate left without pin wakeup");
	a_sleep_resume: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(mode_r == pmc_pkg::M_SLEEP && sleep_wake) |=>
		(mode_r == pmc_pkg::M_RES_SLP) [*8] ##1 (mode_r != pmc_pkg::M_SLEEP))
		else $error("sleep resume wait too short");
	a_hib_resume_max: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(mode_r == pmc_pkg::M_HIB && hib_wake) |=> ##[1:999] mode_r == pmc_pkg::M_ACTIVE)
		else $error("hibernate resume too slow");
	a_hib_clocks_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(mode_r == pmc_pkg::M_HIB) |-> !o_sys_clk_en && o_sub_en == '0 && o_io_hold)
		else $error("clocks running in hibernate");
	a_wake_cpu_on: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(mode_r == pmc_pkg::M_ALT && any_wake) |=> o_sub_en[pmc_pkg::SUB_CPU] && o_mode == 4'h1)
		else $error("cpu not enabled on wakeup");
	a_hib_regs: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(mode_r == pmc_pkg::M_HIB) |-> !o_dreg_en && !o_areg_en && o_hib_reg_en)
		else $error("regulators on in hibernate");
	a_alt_entry: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(mode_r != pmc_pkg::M_ALT && $past(mode_r) != pmc_pkg::M_ALT) ##1
		(mode_r == pmc_pkg::M_ALT) |-> $past(req_alt))
		else $error("alternate entered without request");
	// cpu stays on after a wakeup while its template bit is not cleared again
	a_cpu_wake_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(o_wake_pulse && mode_nxt == pmc_pkg::M_ACTIVE
		&& i_active_tpl[pmc_pkg::SUB_CPU] == cpu_tpl_r) |=> o_sub_en[pmc_pkg::SUB_CPU])
		else $error("cpu not kept on after wakeup");
	// self-disable takes the cpu clock away on the next edge
	a_cpu_self_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(cpu_self_off && !any_wake && mode_nxt == pmc_pkg::M_ACTIVE)
		|=> !o_sub_en[pmc_pkg::SUB_CPU])
		else $error("cpu kept on after self-disable");
	// sleep gates the system clock and all but the kept subsystems
	a_sleep_gated: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(mode_r == pmc_pkg::M_SLEEP) |-> !o_sys_clk_en
		&& (o_sub_en & ~pmc_pkg::SLEEP_KEEP) == '0)
		else $error("subsystem running in sleep");
	// exactly one low-speed oscillator runs in sleep
	a_sleep_one_osc: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(mode_r == pmc_pkg::M_SLEEP)
		|-> o_internal_low_speed_osc_en != o_khz_crystal_osc_en)
		else $error("slow oscillator choice wrong in sleep");
	// outputs and state stay held through the hibernate resume wait
	a_hib_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(mode_r == pmc_pkg::M_RES_HIB) |-> o_io_hold && o_retain && !o_sys_clk_en)
		else $error("hold released during hibernate resume");
endmodule
`default_nettype wire

// file: tb/power_mode_controller_test.sv
/*
 * self-checking bench for the global power-mode controller: reset values,
 * templates, alternate, sleep and hibernate entry and exit, reset events.
 * assumes the design's pmc_pkg constants and the hand-over timing.
 */
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller_test;
	// clock, reset and firmware controls
	logic                      i_sys_clk;
	logic                      i_rst;
	logic [pmc_pkg::NSUB-1:0]  i_active_tpl;
	logic [pmc_pkg::NSUB-1:0]  i_alt_tpl;
	logic                      i_mode_req;
	logic [1:0]                i_mode_req_sel;
	logic                      i_dreg_en_clr;
	logic                      i_areg_en_clr;
	logic                      i_osc_sel_khz;
	// wakeup and reset events
	logic [pmc_pkg::NWAKE-1:0] i_sleep_wake;
	logic                      i_any_irq;
	logic [2:0]                rst_ev;
	// observed outputs
	logic [pmc_pkg::NSUB-1:0]  o_sub_en;
	logic                      o_sys_clk_en;
	logic                      o_slow_osc_en;
	logic                      o_khz_en;
	logic                      o_dreg_en;
	logic                      o_areg_en;
	logic                      o_hib_reg_en;
	logic                      o_io_hold;
	logic                      o_retain;
	logic [3:0]                o_mode;
	logic                      o_wake_pulse;
	// bookkeeping
	int                        num_errors = 0;
	int                        checks_done = 0;
	logic [3:0]                exp_q[$];
	logic [3:0]                prev_mode = 4'h1;
	logic [31:0]               seed = 32'h00011E61;
	int                        n;
	int                        cnt;

	power_mode_controller DUT (
		.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_active_tpl(i_active_tpl),
		.i_alt_tpl(i_alt_tpl), .i_mode_req(i_mode_req), .i_mode_req_sel(i_mode_req_sel),
		.i_dreg_en_clr(i_dreg_en_clr), .i_areg_en_clr(i_areg_en_clr),
		.i_osc_sel_khz(i_osc_sel_khz), .i_sleep_wake(i_sleep_wake), .i_any_irq(i_any_irq),
		.i_external_reset_pin(rst_ev[0]), .i_watchdog_reset(rst_ev[1]),
		.i_precision_reset(rst_ev[2]), .o_sub_en(o_sub_en), .o_sys_clk_en(o_sys_clk_en),
		.o_internal_low_speed_osc_en(o_slow_osc_en), .o_khz_crystal_osc_en(o_khz_en),
		.o_dreg_en(o_dreg_en), .o_areg_en(o_areg_en), .o_hib_reg_en(o_hib_reg_en),
		.o_io_hold(o_io_hold), .o_retain(o_retain), .o_mode(o_mode),
		.o_wake_pulse(o_wake_pulse));

	// 100 ns clock
	initial begin
		i_sys_clk = 1'b0;
		forever #50 i_sys_clk = ~i_sys_clk;
	end

	// xorshift source for templates
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// one comparison, counted
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// verdict and end of run
	task automatic wrap_up();
		if (exp_q.size() != 0)
			num_errors++;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// one-cycle mode request; expected mode noted unless refusal is meant
	task automatic req(input logic [1:0] sel, input logic [3:0] m, input bit note);
		if (note)
			exp_q.push_back(m);
		i_mode_req = 1'b1;
		i_mode_req_sel = sel;
		@(negedge i_sys_clk);
		i_mode_req = 1'b0;
		repeat (2) @(negedge i_sys_clk);
	endtask

	// bounded wait for a mode, n counts cycles taken
	task automatic wait_mode(input logic [3:0] m, input int lim);
		n = 0;
		do begin
			@(negedge i_sys_clk);
			n++;
		end while (o_mode !== m && n < lim);
		chk(n < lim, 1'h1);
	endtask

	// watcher: each mode change takes the oldest note
	always @(negedge i_sys_clk) begin
		if (!i_rst && o_mode !== prev_mode) begin
			if (exp_q.size() == 0)
				chk(o_mode, prev_mode);
			else
				chk(o_mode, exp_q.pop_front());
			prev_mode = o_mode;
		end
	end

	// watchdog on a hang
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		num_errors++;
		wrap_up();
	end

	// main sequence
	initial begin
		i_rst = 1'b1;
		{i_mode_req, i_mode_req_sel, i_dreg_en_clr, i_areg_en_clr} = 5'h00;
		{i_osc_sel_khz, i_any_irq, i_sleep_wake, rst_ev} = 11'h000;
		i_active_tpl = 8'hFF;
		i_alt_tpl = 8'hFF;
		repeat (4) @(negedge i_sys_clk);
		i_rst = 1'b0;
		chk(o_mode, 4'h1);
		chk({o_dreg_en, o_areg_en, o_hib_reg_en}, 3'h7);
		$display("test reset done");
		// active template drives enables directly
		for (int k = 0; k < 4; k++) begin
			i_active_tpl = xs() | 8'h01;
			repeat (2) @(negedge i_sys_clk);
			chk(o_sub_en, i_active_tpl);
		end
		$display("test template done");
		// alternate mode, refused request, wake on any interrupt
		i_alt_tpl = xs() & 8'hFC;
		req(pmc_pkg::REQ_ALT, 4'h2, 1'b1);
		chk(o_sub_en, i_alt_tpl);
		req(pmc_pkg::REQ_SLEEP, 4'h4, 1'b0);
		chk(o_mode, 4'h2);
		exp_q.push_back(4'h1);
		i_any_irq = 1'b1;
		wait_mode(4'h1, 20);
		i_any_irq = 1'b0;
		repeat (2) @(negedge i_sys_clk);
		$display("test alternate done");
		// sleep with each wakeup source, cpu turned off by its own template bit
		i_active_tpl = 8'hFE;
		repeat (2) @(negedge i_sys_clk);
		chk(o_sub_en[0], 1'h0);
		for (int k = 0; k < pmc_pkg::NWAKE; k++) begin
			i_osc_sel_khz = k[0];
			req(pmc_pkg::REQ_SLEEP, 4'h4, 1'b1);
			chk({o_sys_clk_en, o_slow_osc_en, o_khz_en}, {1'h0, !k[0], k[0]});
			chk(o_sub_en & ~pmc_pkg::SLEEP_KEEP, 8'h00);
			if (k == 0) begin
				cnt = 0;
				repeat (128) begin
					@(negedge i_sys_clk);
					cnt += o_dreg_en;
				end
				chk(cnt, 2);
			end
			exp_q.push_back(4'h1);
			i_sleep_wake[k] = 1'b1;
			wait_mode(4'h1, 400);
			i_sleep_wake = 6'h00;
			chk(n >= pmc_pkg::SLEEP_RESUME_CYC && n <= pmc_pkg::SLEEP_RESUME_CYC + 8, 1'h1);
			chk({o_wake_pulse, o_sub_en[0]}, 2'h3);
			repeat (3) @(negedge i_sys_clk);
			chk(o_sub_en[0], 1'h1);
		end
		i_osc_sel_khz = 1'b0;
		i_active_tpl = 8'hFF;
		$display("test sleep done");
		// hibernate: retention, refused wakeups, pin wake
		req(pmc_pkg::REQ_HIB, 4'h8, 1'b1);
		chk({o_io_hold, o_retain, o_sys_clk_en, o_dreg_en, o_areg_en, o_hib_reg_en}, 6'h31);
		i_sleep_wake = 6'h3D;
		i_any_irq = 1'b1;
		repeat (50) @(negedge i_sys_clk);
		chk(o_mode, 4'h8);
		{i_sleep_wake, i_any_irq} = 7'h00;
		exp_q.push_back(4'h1);
		i_sleep_wake[pmc_pkg::WK_PIN] = 1'b1;
		wait_mode(4'h1, 1200);
		i_sleep_wake = 6'h00;
		chk(n < 1000, 1'h1);
		repeat (2) @(negedge i_sys_clk);
		$display("test hibernate done");
		// each reset event wakes from sleep
		for (int j = 0; j < 3; j++) begin
			req(pmc_pkg::REQ_SLEEP, 4'h4, 1'b1);
			exp_q.push_back(4'h1);
			rst_ev[j] = 1'b1;
			wait_mode(4'h1, 400);
			chk(n >= pmc_pkg::SLEEP_RESUME_CYC, 1'h1);
			rst_ev = 3'h0;
			repeat (2) @(negedge i_sys_clk);
		end
		$display("test reset events done");
		// regulator enables cleared by firmware
		i_dreg_en_clr = 1'b1;
		@(negedge i_sys_clk);
		i_dreg_en_clr = 1'b0;
		i_areg_en_clr = 1'b1;
		@(negedge i_sys_clk);
		i_areg_en_clr = 1'b0;
		repeat (2) @(negedge i_sys_clk);
		chk({o_dreg_en, o_areg_en}, 2'h0);
		$display("test regulators done");
		wrap_up();
	end
endmodule
`default_nettype wire
